// ### core/spr_pkg.sv
/*
 * Shared constants and types for the shunt power result scaler.
 * Assumes a 25 MHz system clock and 12-bit conversion codes from the front end.
 */
package spr_pkg;

	// Register offsets
	localparam logic [5:0] SPR_OFS_CONFIG  = 6'h00;
	localparam logic [5:0] SPR_OFS_SHUNT   = 6'h01;
	localparam logic [5:0] SPR_OFS_BUS     = 6'h02;
	localparam logic [5:0] SPR_OFS_POWER   = 6'h03;
	localparam logic [5:0] SPR_OFS_CURRENT = 6'h04;
	localparam logic [5:0] SPR_OFS_CAL     = 6'h05;
	localparam logic [5:0] SPR_OFS_STATUS  = 6'h06;
	localparam logic [5:0] SPR_OFS_MAKER   = 6'h3E;
	localparam logic [5:0] SPR_OFS_PART    = 6'h3F;

	// Field positions and reset values
	localparam int          SPR_RSV_LOW     = 4;
	localparam int          SPR_ST_READY    = 3;
	localparam int          SPR_ST_OFLOW    = 2;
	localparam int          SPR_PART_LOW    = 3;
	localparam logic [15:0] SPR_CFG_RST     = 16'h0000;
	localparam logic [14:0] SPR_CAL_RST     = 15'h0000;

	// Conversion times in microseconds and derived cycle counts
	localparam int SPR_CLK_MHZ   = 25;
	localparam int SPR_CONV0_US  = 140;
	localparam int SPR_CONV1_US  = 204;
	localparam int SPR_CONV2_US  = 332;
	localparam int SPR_CONV3_US  = 588;
	localparam int SPR_CONV0_CYC = SPR_CONV0_US * SPR_CLK_MHZ;
	localparam int SPR_CONV1_CYC = SPR_CONV1_US * SPR_CLK_MHZ;
	localparam int SPR_CONV2_CYC = SPR_CONV2_US * SPR_CLK_MHZ;
	localparam int SPR_CONV3_CYC = SPR_CONV3_US * SPR_CLK_MHZ;

	// Arithmetic scaling
	localparam int         SPR_CUR_SHIFT = 11;
	localparam logic [9:0] SPR_PWR_MUL   = 10'h347;
	localparam int         SPR_PWR_SHIFT = 20;

	// Register access request from the serial front end
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [5:0]  addr;
		logic [15:0] wdata;
	} spr_req_t;

	// Configuration register layout
	typedef struct packed {
		logic [10:0] rsvd;
		logic        shunt_range_select;
		logic [1:0]  avg_sel;
		logic [1:0]  conv_sel;
	} spr_cfg_t;

	typedef enum logic [1:0] {
		SPR_SHUNT_CONV = 2'b00,
		SPR_BUS_CONV   = 2'b01,
		SPR_AVG_WAIT   = 2'b10,
		SPR_CALC       = 2'b11
	} spr_state_t;

endpackage : spr_pkg

// ### core/spr_avg.sv
/*
 * Block averager: sums 2**log2n samples and emits their mean.
 * Assumes log2n is steady across a block; restart drops a partial block.
 */
`timescale 1ns/1ps
module spr_avg
	import spr_pkg::*;
#(
	parameter int W    = 12,
	parameter bit SGN  = 1'b1,
	parameter int LMAX = 6
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	// Sample stream
	input  wire logic         restart,
	input  wire logic         smp_valid,
	input  wire logic [W-1:0] smp,
	input  wire logic [2:0]   log2n,
	// Mean
	output logic              avg_valid,
	output logic [W-1:0]      avg
);

	localparam int AW = W + LMAX;

	logic [AW-1:0]   acc_ff;
	logic [LMAX:0]   cnt_ff;
	logic [W-1:0]    avg_ff;
	logic            vld_ff;
	wire  [AW-1:0]   ext      = SGN ? {{LMAX{smp[W-1]}}, smp} : {{LMAX{1'b0}}, smp};
	wire  [AW-1:0]   sum      = acc_ff + ext;
	wire  [LMAX:0]   last_cnt = ((LMAX+1)'(1) << log2n) - (LMAX+1)'(1);
	wire             last     = (cnt_ff == last_cnt);
	wire  [AW-1:0]   mean     = SGN ? AW'($signed(sum) >>> log2n) : (sum >> log2n);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			acc_ff <= '0;
			cnt_ff <= '0;
			avg_ff <= '0;
			vld_ff <= 1'b0;
		end else begin
			vld_ff <= smp_valid && last && !restart;
			if (restart) begin
				acc_ff <= '0;
				cnt_ff <= '0;
			end else if (smp_valid) begin
				acc_ff <= last ? '0 : sum;
				cnt_ff <= last ? '0 : cnt_ff + (LMAX+1)'(1);
				if (last)
					avg_ff <= mean[W-1:0];
			end
		end
	end

	assign avg_valid = vld_ff;
	assign avg       = avg_ff;

endmodule : spr_avg

// ### core/spr_core.sv
/*
 * Result formatting, current and power arithmetic, identity registers.
 * Assumes a serial front end that presents one-cycle register requests,
 * and an analog front end whose codes are valid when adc_sample pulses.
 */
//
// Contract
// - Maker identity at 0x3E, fixed code
// - Part identity at 0x3F, low bits zero
// - Range bit picks 81.92 or 20.48 mV
// - Shunt step 40 uV or 10 uV
// - Bus step 25.6 mV, to 104.83 V
// - Shunt, bus words: low nibble reserved
// - Shunt result is signed
// - Bus result is unsigned
// - Current recomputed after each shunt result
// - Zero scale factor gives zero current
// - Power step is 32 current steps
// - Shortest conversion time 140 us
// - Averages successive conversions before reporting
// - Ready flag set after all math
// - Overflow flag on current or power overflow
`timescale 1ns/1ps
module spr_core
	import spr_pkg::*;
#(
	parameter logic [15:0] MAKER_CODE = 16'h5A5A, // Arbitrary value
	parameter logic [12:0] DIE_CODE   = 13'h0123, // Arbitrary value
	parameter int          CONV0_CYC  = SPR_CONV0_CYC,
	parameter int          CONV1_CYC  = SPR_CONV1_CYC,
	parameter int          CONV2_CYC  = SPR_CONV2_CYC,
	parameter int          CONV3_CYC  = SPR_CONV3_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Register access
	input  wire spr_req_t    reg_req,
	output logic [15:0]      reg_rdata,
	// Analog front end
	input  wire logic [11:0] adc_shunt_code,
	input  wire logic [11:0] adc_bus_code,
	output logic             adc_range,
	output logic             adc_channel,
	output logic             adc_sample,
	// Status
	output logic             result_ready_flag,
	output logic             arithmetic_overflow_flag
);

	spr_cfg_t    cfg_ff;
	logic [14:0] cal_ff;
	logic [15:0] shunt_ff;
	logic [15:0] bus_ff;
	logic [15:0] cur_ff;
	logic [15:0] pwr_ff;
	logic        rdy_ff;
	logic        oflow_ff;
	logic [15:0] rdata_ff;
	logic [15:0] tmr_ff;
	spr_state_t  st_ff;
	spr_state_t  nxt_st;

	// Register decode
	wire cfg_wr  = reg_req.wr && (reg_req.addr == SPR_OFS_CONFIG);
	wire cal_wr  = reg_req.wr && (reg_req.addr == SPR_OFS_CAL);
	wire stat_rd = reg_req.rd && (reg_req.addr == SPR_OFS_STATUS);

	// Conversion timer, shared by the shunt and bus measurements
	wire [15:0] conv_len = (cfg_ff.conv_sel == 2'd0) ? 16'(CONV0_CYC) :
	                       (cfg_ff.conv_sel == 2'd1) ? 16'(CONV1_CYC) :
	                       (cfg_ff.conv_sel == 2'd2) ? 16'(CONV2_CYC) : 16'(CONV3_CYC);
	wire        conv_end = (st_ff == SPR_SHUNT_CONV || st_ff == SPR_BUS_CONV)
	                       && (tmr_ff == conv_len - 16'h0001);
	wire        sh_smp   = conv_end && (st_ff == SPR_SHUNT_CONV);
	wire        bus_smp  = conv_end && (st_ff == SPR_BUS_CONV);
	wire [2:0]  log2n    = {cfg_ff.avg_sel, 1'b0};

	// Averagers
	wire        sh_avg_vld;
	wire        bus_avg_vld;
	wire [11:0] sh_avg;
	wire [11:0] bus_avg;

	spr_avg #(.W(12), .SGN(1'b1), .LMAX(6)) u_avg_shunt (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.restart   (cfg_wr),
		.smp_valid (sh_smp),
		.smp       (adc_shunt_code),
		.log2n     (log2n),
		.avg_valid (sh_avg_vld),
		.avg       (sh_avg)
	);

	spr_avg #(.W(12), .SGN(1'b0), .LMAX(6)) u_avg_bus (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.restart   (cfg_wr),
		.smp_valid (bus_smp),
		.smp       (adc_bus_code),
		.log2n     (log2n),
		.avg_valid (bus_avg_vld),
		.avg       (bus_avg)
	);

	// Current: signed code times scale factor, divided by 2**11
	wire signed [11:0] sh_code  = $signed(shunt_ff[15:SPR_RSV_LOW]);
	wire signed [28:0] cur_prod = sh_code * $signed({1'b0, cal_ff});
	wire signed [28:0] cur_shr  = cur_prod >>> SPR_CUR_SHIFT;
	wire               cur_fit  = (cur_shr[28:15] == {14{cur_shr[15]}});
	wire        [15:0] cur_sat  = cur_shr[28] ? 16'h8000 : 16'h7FFF;
	wire        [15:0] cur_new  = (cal_ff == 15'h0000) ? 16'h0000 :
	                              (cur_fit ? cur_shr[15:0] : cur_sat);

	// Power: magnitude of current times bus code, divided by 1250
	wire        [15:0] cur_mag  = cur_ff[15] ? 16'(-cur_ff) : cur_ff;
	wire        [27:0] pwr_raw  = cur_mag * bus_ff[15:SPR_RSV_LOW];
	wire        [37:0] pwr_scl  = pwr_raw * SPR_PWR_MUL;
	wire        [17:0] pwr_shr  = pwr_scl[37:SPR_PWR_SHIFT];
	wire               pwr_fit  = (pwr_shr[17:16] == 2'b00);
	wire        [15:0] pwr_new  = pwr_fit ? pwr_shr[15:0] : 16'hFFFF;

	// Sequencer
	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			SPR_SHUNT_CONV: if (conv_end) nxt_st = SPR_BUS_CONV;
			SPR_BUS_CONV:   if (conv_end) nxt_st = SPR_AVG_WAIT;
			SPR_AVG_WAIT:   nxt_st = bus_avg_vld ? SPR_CALC : SPR_SHUNT_CONV;
			SPR_CALC:       nxt_st = SPR_SHUNT_CONV;
		endcase
		if (cfg_wr)
			nxt_st = SPR_SHUNT_CONV;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff  <= SPR_SHUNT_CONV;
			tmr_ff <= 16'h0000;
		end else begin
			st_ff  <= nxt_st;
			tmr_ff <= (conv_end || cfg_wr || nxt_st != st_ff) ? 16'h0000 : tmr_ff + 16'h0001;
		end
	end

	// Current is formed in AVG_WAIT, power one cycle later in CALC
	wire cur_step  = (st_ff == SPR_AVG_WAIT) && bus_avg_vld && !cfg_wr;
	wire pwr_step  = (st_ff == SPR_CALC) && !cfg_wr;
	wire oflow_set = (cur_step && cal_ff != 15'h0000 && !cur_fit)
	                 || (pwr_step && !pwr_fit);

	// Registers written by software
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_ff <= SPR_CFG_RST;
			cal_ff <= SPR_CAL_RST;
		end else begin
			if (cfg_wr)
				cfg_ff <= reg_req.wdata;
			if (cal_wr)
				cal_ff <= reg_req.wdata[14:0];
		end
	end

	// Result words; shunt and bus keep the low nibble at zero
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			shunt_ff <= 16'h0000;
			bus_ff   <= 16'h0000;
			cur_ff   <= 16'h0000;
			pwr_ff   <= 16'h0000;
		end else begin
			if (sh_avg_vld)
				shunt_ff <= {sh_avg, 4'h0};
			if (bus_avg_vld)
				bus_ff <= {bus_avg, 4'h0};
			if (cur_step)
				cur_ff <= cur_new;
			if (pwr_step)
				pwr_ff <= pwr_new;
		end
	end

	// Flags: a set in the clearing cycle wins
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdy_ff <= 1'b0;
			oflow_ff <= 1'b0;
		end else begin
			rdy_ff <= pwr_step || (rdy_ff && !cfg_wr && !stat_rd);
			oflow_ff <= oflow_set || (oflow_ff && !stat_rd);
		end
	end

	// Read data, one cycle after the request
	wire [15:0] status_word = (16'(rdy_ff) << SPR_ST_READY) | (16'(oflow_ff) << SPR_ST_OFLOW);
	wire [15:0] rd_mux =
		(reg_req.addr == SPR_OFS_CONFIG)  ? cfg_ff :
		(reg_req.addr == SPR_OFS_SHUNT)   ? shunt_ff :
		(reg_req.addr == SPR_OFS_BUS)     ? bus_ff :
		(reg_req.addr == SPR_OFS_POWER)   ? pwr_ff :
		(reg_req.addr == SPR_OFS_CURRENT) ? cur_ff :
		(reg_req.addr == SPR_OFS_CAL)     ? {1'b0, cal_ff} :
		(reg_req.addr == SPR_OFS_STATUS)  ? status_word :
		(reg_req.addr == SPR_OFS_MAKER)   ? MAKER_CODE :
		(reg_req.addr == SPR_OFS_PART)    ? {DIE_CODE, 3'b000} :
		16'h0000;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			rdata_ff <= 16'h0000;
		else if (reg_req.rd)
			rdata_ff <= rd_mux;
	end

	assign reg_rdata                = rdata_ff;
	assign adc_range                = cfg_ff.shunt_range_select;
	assign adc_channel              = (st_ff == SPR_BUS_CONV);
	assign adc_sample               = conv_end;
	assign result_ready_flag        = rdy_ff;
	assign arithmetic_overflow_flag = oflow_ff;

endmodule : spr_core

// ### verif/spr_core_props.sv
/* Checker on the spr_core ports.
 * Assumes conversion counts of at least 2 cycles. */
`timescale 1ns/1ps
module spr_core_props
	import spr_pkg::*;
#(
	parameter logic [15:0] MAKER_CODE = 16'h5A5A,
	parameter logic [12:0] DIE_CODE   = 13'h0123
) (
	// Clock, reset, registers
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire spr_req_t    reg_req,
	input wire logic [15:0] reg_rdata,
	// Front end and status
	input wire logic        adc_range,
	input wire logic        adc_channel,
	input wire logic        adc_sample,
	input wire logic        result_ready_flag,
	input wire logic        arithmetic_overflow_flag
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_maker_read: assert property (reg_req.rd && reg_req.addr == 6'h3E |=> reg_rdata == MAKER_CODE)
		else $error("maker read wrong");
	a_part_read: assert property (reg_req.rd && reg_req.addr == 6'h3F |=> reg_rdata == {DIE_CODE, 3'h0})
		else $error("part read wrong");
	a_range_write: assert property (reg_req.wr && reg_req.addr == 6'h00
		|=> adc_range == $past(reg_req.wdata[4]))
		else $error("range not taken");
	a_word_nibble: assert property (reg_req.rd && (reg_req.addr == 6'h01 || reg_req.addr == 6'h02)
		|=> reg_rdata[3:0] == 4'h0)
		else $error("reserved nibble set");
	a_bus_follows: assert property (adc_sample && !adc_channel && !(reg_req.wr && reg_req.addr == 6'h00)
		|=> adc_channel)
		else $error("bus conversion missing");
	a_ready_math: assert property ($rose(result_ready_flag) |-> $past(adc_sample && adc_channel, 3))
		else $error("ready at wrong time");
	a_status_flags: assert property (reg_req.rd && reg_req.addr == 6'h06
		|=> reg_rdata[3:2] == $past({result_ready_flag, arithmetic_overflow_flag}))
		else $error("status bits wrong");
	a_cfg_restart: assert property (reg_req.wr && reg_req.addr == 6'h00 |=> !adc_channel [*2])
		else $error("no restart");
endmodule : spr_core_props

bind spr_core spr_core_props #(.MAKER_CODE(MAKER_CODE), .DIE_CODE(DIE_CODE)) u_props (
	.sys_clk(sys_clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.adc_range(adc_range), .adc_channel(adc_channel), .adc_sample(adc_sample),
	.result_ready_flag(result_ready_flag), .arithmetic_overflow_flag(arithmetic_overflow_flag));

// ### verif/spr_afe_model.sv
/* Analog front end model: codes are valid only in the sampling cycle.
 * Assumes the bench sets the values to convert. */
`timescale 1ns/1ps
module spr_afe_model (
	// Values to convert
	input  wire logic [11:0] shunt_val,
	input  wire logic [11:0] bus_val,
	// Conversion link
	input  wire logic        adc_channel,
	input  wire logic        adc_sample,
	output logic [11:0]      adc_shunt_code,
	output logic [11:0]      adc_bus_code
);
	// Codes are not held outside the sampling cycle
	assign adc_shunt_code = (adc_sample && !adc_channel) ? shunt_val : ~shunt_val;
	assign adc_bus_code   = (adc_sample && adc_channel) ? bus_val : ~bus_val;
endmodule : spr_afe_model

// ### verif/spr_core_bench.sv
/* Bench for spr_core: table of result cases, then hand tests.
 * Assumes short conversion counts of 8 to 11 cycles. */
`timescale 1ns/1ps
module spr_core_bench
	import spr_pkg::*;
;
	localparam logic [15:0] MK = 16'h1234; // Arbitrary value
	localparam logic [12:0] DC = 13'h0ABC; // Arbitrary value
	typedef struct {logic [11:0] sh; logic [11:0] bv; logic [14:0] sc; logic [15:0] cur;
		logic [15:0] pwr; logic oflow;} spr_row_t;
	// Inputs, then expected current, power and overflow
	spr_row_t    rows [5] = '{
		'{12'h100, 12'h200, 15'h0800, 16'h0100, 16'h0068, 1'b0},
		'{12'hF00, 12'h7FF, 15'h1000, 16'hFE00, 16'h0346, 1'b0},
		'{12'h7FF, 12'hFFF, 15'h0000, 16'h0000, 16'h0000, 1'b0},
		'{12'h7FF, 12'hFFF, 15'h7FFF, 16'h7FEF, 16'hFFFF, 1'b1},
		'{12'h800, 12'h001, 15'h7FFF, 16'h8001, 16'h001A, 1'b0}};
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	spr_req_t    reg_req = '0;
	logic [11:0] shunt_val = 12'h000, bus_val = 12'h000, adc_shunt_code, adc_bus_code;
	logic [15:0] reg_rdata, rd_v;
	logic        adc_range, adc_channel, adc_sample, result_ready_flag, arithmetic_overflow_flag;
	int          n_errors = 0, cmp_count = 0, n, i;

	spr_core #(.MAKER_CODE(MK), .DIE_CODE(DC), .CONV0_CYC(8), .CONV1_CYC(9), .CONV2_CYC(10),
		.CONV3_CYC(11)) dut (.sys_clk(sys_clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.adc_shunt_code(adc_shunt_code), .adc_bus_code(adc_bus_code), .adc_range(adc_range),
		.adc_channel(adc_channel), .adc_sample(adc_sample), .result_ready_flag(result_ready_flag),
		.arithmetic_overflow_flag(arithmetic_overflow_flag));
	spr_afe_model afe (.shunt_val(shunt_val), .bus_val(bus_val), .adc_channel(adc_channel),
		.adc_sample(adc_sample), .adc_shunt_code(adc_shunt_code), .adc_bus_code(adc_bus_code));

	always #20 sys_clk = ~sys_clk;

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge sys_clk);
		reg_req = '0;
	endtask : wr
	task automatic rd(input logic [5:0] a);
		@(negedge sys_clk);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(negedge sys_clk);
		reg_req = '0;
		rd_v = reg_rdata;
	endtask : rd
	task automatic wait_rdy;
		n = 0;
		while (result_ready_flag !== 1'b1) begin
			@(negedge sys_clk);
			n++;
			if (n > 2000) begin
				chk("ready wait", 16'h0001, 16'h0000);
				conclude();
			end
		end
	endtask : wait_rdy

	initial begin
		repeat (2) @(negedge sys_clk);
		rstn = 1'b1;
		for (i = 0; i < 5; i++) begin
			shunt_val = rows[i].sh;
			bus_val = rows[i].bv;
			wr(SPR_OFS_CAL, {1'b0, rows[i].sc});
			wr(SPR_OFS_CONFIG, 16'h0000);
			wait_rdy();
			rd(SPR_OFS_STATUS);
			wait_rdy();
			rd(SPR_OFS_SHUNT);
			chk("shunt", {rows[i].sh, 4'h0}, rd_v);
			rd(SPR_OFS_BUS);
			chk("bus", {rows[i].bv, 4'h0}, rd_v);
			rd(SPR_OFS_CURRENT);
			chk("current", rows[i].cur, rd_v);
			rd(SPR_OFS_POWER);
			chk("power", rows[i].pwr, rd_v);
			rd(SPR_OFS_STATUS);
			chk("status", {12'h000, 1'b1, rows[i].oflow, 2'b00}, rd_v);
		end
		rd(SPR_OFS_MAKER);
		chk("maker", MK, rd_v);
		wr(SPR_OFS_PART, 16'hFFFF);
		rd(SPR_OFS_PART);
		chk("part", {DC, 3'h0}, rd_v);
		rd(6'h20);
		chk("unmapped", 16'h0000, rd_v);
		wr(SPR_OFS_CONFIG, 16'h0014);
		chk("range", 16'h0001, {15'h0000, adc_range});
		wait_rdy();
		chk("average wait", 16'(4 * (2 * 8 + 1) + 1), 16'(n));
		rd(SPR_OFS_SHUNT);
		chk("average shunt", {rows[4].sh, 4'h0}, rd_v);
		rd(SPR_OFS_BUS);
		chk("average bus", {rows[4].bv, 4'h0}, rd_v);
		rd(SPR_OFS_STATUS);
		chk("ready clear", 16'h0000, {15'h0000, result_ready_flag});
		// Conversion codes 1 to 3 with averaging codes 1 to 3, timed from the config write
		wr(SPR_OFS_CONFIG, 16'h0006);
		wait_rdy();
		chk("conv 10 avg 4", 16'(4 * (2 * 10 + 1) + 1), 16'(n));
		wr(SPR_OFS_CONFIG, 16'h0009);
		wait_rdy();
		chk("conv 9 avg 16", 16'(16 * (2 * 9 + 1) + 1), 16'(n));
		wr(SPR_OFS_CONFIG, 16'h000F);
		wait_rdy();
		chk("conv 11 avg 64", 16'(64 * (2 * 11 + 1) + 1), 16'(n));
		rstn = 1'b0;
		@(negedge sys_clk);
		chk("reset range", 16'h0000, {15'h0000, adc_range});
		rstn = 1'b1;
		rd(SPR_OFS_CONFIG);
		chk("config reset", 16'h0000, rd_v);
		rd(SPR_OFS_CAL);
		chk("scale reset", 16'h0000, rd_v);
		conclude();
	end
endmodule : spr_core_bench
